// ==== hdl/cerr_pkg.sv ====
package cerr_pkg;
    // queue and command widths
    localparam int QID_W = 4;
    localparam int NQ = 16;
    localparam int CID_W = 8;
    localparam int SC_W = 8;
    localparam int SCT_W = 3;
    // status code types
    localparam logic [2:0] SCT_GENERIC = 3'h0;
    localparam logic [2:0] SCT_MEDIA = 3'h2;
    // generic status codes
    localparam logic [7:0] SC_SUCCESS = 8'h00;
    localparam logic [7:0] SC_DATA_XFER_ERR = 8'h04;
    localparam logic [7:0] SC_INTERNAL_ERR = 8'h06;
    localparam logic [7:0] SC_ABORT_SQ_DEL = 8'h08;
    // media status codes
    localparam logic [7:0] SC_WRITE_FAULT = 8'h80;
    localparam logic [7:0] SC_UNRECOV_READ = 8'h81;
    localparam logic [7:0] SC_GUARD_ERR = 8'h82;
    // reset values
    localparam logic RST_FATAL = 1'h0;
    localparam logic [15:0] RST_QALLOC = 16'h0000;
    // consecutive posting failures before the flag is set
    localparam logic [2:0] POST_FAIL_LIMIT = 3'h3;
    // completion engine states
    typedef enum logic [2:0] {
        CE_IDLE = 3'h1,
        CE_RUN = 3'h2,
        CE_DONE = 3'h4
    } cerr_state_t;
endpackage

// ==== hdl/cerr_status_select.sv ====
`timescale 1ns/1ps
`default_nettype none
// picks the completion status from the error sources of one command
module cerr_status_select (
    // error sources
    input wire logic sqDeleted,
    input wire logic busAbort,
    input wire logic internalErr,
    input wire logic mediaErr,
    input wire logic [2:0] mediaKind,
    input wire logic limitedRetry,
    // chosen status
    output logic [2:0] statusType,
    output logic [7:0] statusCode,
    output logic retry
);
    wire logic anyGeneric;
    wire logic [7:0] genericCode;
    wire logic [7:0] mediaCode;
    // lowest numerical generic code wins when several coexist
    assign genericCode = busAbort ? cerr_pkg::SC_DATA_XFER_ERR :
        internalErr ? cerr_pkg::SC_INTERNAL_ERR :
        sqDeleted ? cerr_pkg::SC_ABORT_SQ_DEL : cerr_pkg::SC_SUCCESS;
    assign anyGeneric = busAbort | internalErr | sqDeleted;
    // media failure type decides the code
    assign mediaCode = (mediaKind == 3'h1) ? cerr_pkg::SC_UNRECOV_READ :
        (mediaKind == 3'h2) ? cerr_pkg::SC_GUARD_ERR : cerr_pkg::SC_WRITE_FAULT;
    // generic codes sit in type 0, numerically below any media type
    assign statusType = anyGeneric ? cerr_pkg::SCT_GENERIC :
        (mediaErr ? cerr_pkg::SCT_MEDIA : cerr_pkg::SCT_GENERIC);
    assign statusCode = anyGeneric ? genericCode :
        (mediaErr ? mediaCode : cerr_pkg::SC_SUCCESS);
    // retry may help for transient faults, never after a deletion or limited retry
    assign retry = (anyGeneric | mediaErr) & ~sqDeleted & ~limitedRetry &
        (internalErr | mediaErr) & ~busAbort;
endmodule
`default_nettype wire

// ==== hdl/cerr_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module cerr_unit (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // queue management
    input wire logic queueCreate,
    input wire logic queueDelete,
    input wire logic deleteIsSq,
    input wire logic [3:0] queueId,
    output logic [15:0] queueAllocated,
    // command start
    input wire logic cmdStart,
    input wire logic [3:0] cmdQueue,
    input wire logic [7:0] cmdId,
    input wire logic cmdLimitedRetry,
    output logic cmdBusy,
    // error sources during execution
    input wire logic mediaErr,
    input wire logic [2:0] mediaKind,
    input wire logic readErr,
    input wire logic busAbort,
    input wire logic internalErr,
    input wire logic execDone,
    // data transfer control
    input wire logic stopOnReadErr,
    output logic dataXferEnable,
    output logic recoveryAllowed,
    // completion posting
    output logic cplValid,
    input wire logic cplReady,
    input wire logic cplPostFail,
    output logic [7:0] cplCmdId,
    output logic [3:0] cplQueue,
    output logic [2:0] cplStatusType,
    output logic [7:0] cplStatusCode,
    output logic cplRetry,
    // controller status word bit
    output logic controller_fatal_flag
);
    // every check in this unit samples on the core clock and rests during reset
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    cerr_pkg::cerr_state_t state_r, state_nxt;
    logic [15:0] qAlloc_r;
    logic [7:0] cmdId_r;
    logic [3:0] cmdQ_r;
    logic limRetry_r, busErr_r, intErr_r, medErr_r, sqDel_r, readStop_r, fatal_r;
    logic [2:0] medKind_r;
    logic [2:0] failCnt_r;
    logic [2:0] selType;
    logic [7:0] selCode;
    logic selRetry;
    logic [2:0] cplType_r;
    logic [7:0] cplCode_r;
    logic cplRetry_r;
    wire logic running = (state_r == cerr_pkg::CE_RUN);
    wire logic delHitsCmd = queueDelete & deleteIsSq & (queueId == cmdQ_r) & running;
    // bus errors stop the command at once, as do deletions of its queue
    wire logic abortNow = running & (busAbort | delHitsCmd);
    wire logic finishNow = running & (execDone | abortNow);
    wire logic postOk = cplValid & cplReady & ~cplPostFail;
    wire logic postBad = cplValid & cplReady & cplPostFail;
    wire logic startOk = cmdStart & ~fatal_r & qAlloc_r[cmdQueue];
    // error sources of the running command: stored ones merged with this cycle's
    wire logic selSqDel = sqDel_r | delHitsCmd;
    wire logic selBusAbort = busErr_r | (running & busAbort);
    wire logic selIntErr = intErr_r | (running & internalErr);
    wire logic selMedErr = medErr_r | (running & (mediaErr | readErr));
    wire logic [2:0] selMedKind = readErr ? 3'h1 : (mediaErr ? mediaKind : medKind_r);

    cerr_status_select cerr_status_select_i (
        .sqDeleted(selSqDel),
        .busAbort(selBusAbort),
        .internalErr(selIntErr),
        .mediaErr(selMedErr),
        .mediaKind(selMedKind),
        .limitedRetry(limRetry_r),
        .statusType(selType),
        .statusCode(selCode),
        .retry(selRetry)
    );

    // engine sequencing: a failed command still completes and the unit returns to idle
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            cerr_pkg::CE_IDLE: if (startOk) state_nxt = cerr_pkg::CE_RUN;
            cerr_pkg::CE_RUN: if (finishNow) state_nxt = cerr_pkg::CE_DONE;
            cerr_pkg::CE_DONE: if (cplReady) state_nxt = cerr_pkg::CE_IDLE;
            default: state_nxt = cerr_pkg::CE_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) state_r <= cerr_pkg::CE_IDLE;
        else state_r <= state_nxt;
    end
    // a failed command must not strand the engine; the next start needs idle
    a_back_idle: assert property (cplValid && cplReady |=> !cmdBusy)
        else $error("engine stuck after failure");

    // allocation map; a delete frees the queue's slot
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) qAlloc_r <= cerr_pkg::RST_QALLOC;
        else if (queueDelete) qAlloc_r[queueId] <= 1'h0;
        else if (queueCreate) qAlloc_r[queueId] <= 1'h1;
    end
    a_queue_freed: assert property (queueDelete |=> !queueAllocated[$past(queueId)])
        else $error("queue not freed");
    // a freed queue or a fatal controller takes no new command
    a_start_refused: assert property (
        !cmdBusy && cmdStart && (!queueAllocated[cmdQueue] || controller_fatal_flag) |=> !cmdBusy)
        else $error("start taken while refused");

    // per-command error capture, cleared at each start
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cmdId_r <= 8'h00;
            cmdQ_r <= 4'h0;
            limRetry_r <= 1'h0;
            busErr_r <= 1'h0;
            intErr_r <= 1'h0;
            medErr_r <= 1'h0;
            medKind_r <= 3'h0;
            sqDel_r <= 1'h0;
            readStop_r <= 1'h0;
        end else if (state_r == cerr_pkg::CE_IDLE && state_nxt == cerr_pkg::CE_RUN) begin
            cmdId_r <= cmdId;
            cmdQ_r <= cmdQueue;
            limRetry_r <= cmdLimitedRetry;
            busErr_r <= 1'h0;
            intErr_r <= 1'h0;
            medErr_r <= 1'h0;
            medKind_r <= 3'h0;
            sqDel_r <= 1'h0;
            readStop_r <= 1'h0;
        end else if (running) begin
            busErr_r <= busErr_r | busAbort;
            intErr_r <= intErr_r | internalErr;
            medErr_r <= medErr_r | mediaErr | readErr;
            if (readErr) medKind_r <= 3'h1;
            else if (mediaErr) medKind_r <= mediaKind;
            sqDel_r <= sqDel_r | delHitsCmd;
            readStop_r <= readStop_r | (readErr & stopOnReadErr);
        end
    end
    // the limited-retry setting given at start must gate recovery for the whole command
    a_recovery_gate: assert property (
        $rose(running) |-> recoveryAllowed != $past(cmdLimitedRetry))
        else $error("recovery despite limit");
    // a bus abort ends the command and its transfer at once
    a_bus_stop: assert property (running && busAbort |=> !dataXferEnable && !running)
        else $error("transfer not stopped");

    // completion entry is latched as the command finishes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cplType_r <= 3'h0;
            cplCode_r <= 8'h00;
            cplRetry_r <= 1'h0;
        end else if (finishNow) begin
            cplType_r <= selType;
            cplCode_r <= selCode;
            cplRetry_r <= selRetry;
        end
    end
    // deleting the command's queue ends it with the abort code or a lower coexisting one
    a_sq_abort: assert property (
        delHitsCmd |=> cplValid && cplStatusType == cerr_pkg::SCT_GENERIC &&
        cplStatusCode != cerr_pkg::SC_SUCCESS && cplStatusCode <= cerr_pkg::SC_ABORT_SQ_DEL)
        else $error("queue delete not aborted");
    a_bus_abort: assert property (
        running && busAbort |=> cplValid && cplStatusCode == cerr_pkg::SC_DATA_XFER_ERR)
        else $error("bus abort status wrong");
    // an internal error does not end the command; its code shows once the command finishes
    a_internal_code: assert property (
        finishNow && (intErr_r || internalErr) && !busAbort && !delHitsCmd |=>
        cplValid && cplStatusCode == cerr_pkg::SC_INTERNAL_ERR)
        else $error("internal code wrong");
    a_retry_limited: assert property (cplValid && limRetry_r |-> !cplRetry)
        else $error("retry with limited retry");
    c_media_err: cover property (cplValid && cplStatusType == cerr_pkg::SCT_MEDIA);
    c_sq_del: cover property (delHitsCmd);
    c_bus_abort: cover property (running && busAbort);

    // repeated posting failure means completions cannot reach the host
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) failCnt_r <= 3'h0;
        else if (postOk) failCnt_r <= 3'h0;
        else if (postBad && failCnt_r != cerr_pkg::POST_FAIL_LIMIT) failCnt_r <= failCnt_r + 3'h1;
    end

    // sticky until controller reset; no interrupt path exists for it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) fatal_r <= cerr_pkg::RST_FATAL;
        else if (failCnt_r == cerr_pkg::POST_FAIL_LIMIT) fatal_r <= 1'h1;
    end
    a_fatal_sticky: assert property (fatal_r |=> fatal_r)
        else $error("fatal flag dropped");
    a_fatal_set: assert property ((failCnt_r == cerr_pkg::POST_FAIL_LIMIT) |=> fatal_r)
        else $error("fatal not set");
    c_fatal: cover property ($rose(fatal_r));

    // outputs
    assign queueAllocated = qAlloc_r;
    assign cmdBusy = ~(state_r == cerr_pkg::CE_IDLE);
    assign dataXferEnable = running & ~readStop_r & ~busErr_r;
    assign recoveryAllowed = running & ~limRetry_r;
    assign cplValid = (state_r == cerr_pkg::CE_DONE);
    assign cplCmdId = cmdId_r;
    assign cplQueue = cmdQ_r;
    assign cplStatusType = cplType_r;
    assign cplStatusCode = cplCode_r;
    assign cplRetry = cplRetry_r;
    assign controller_fatal_flag = fatal_r;
endmodule
`default_nettype wire

// ==== test/cerr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host side that takes completion entries off the completion queue
module cerr_host_model (
    // clock
    input wire logic clock,
    // completion handshake
    input wire logic cplValid,
    output logic cplReady,
    output logic cplPostFail,
    // bench controls: failed posting, acceptance delay in cycles
    input wire logic failPost,
    input wire logic [3:0] lag
);
    logic [3:0] waitCnt;
    wire take = cplValid && !cplReady && waitCnt >= lag;
    initial begin
        cplReady = 1'b0;
        cplPostFail = 1'b0;
        waitCnt = 4'h0;
    end
    // one-cycle accept after lag; a failed post leaves the entry unseen by software
    always @(negedge clock) begin
        cplReady <= take;
        cplPostFail <= take && failPost;
        waitCnt <= (cplValid && !cplReady) ? waitCnt + 4'h1 : 4'h0;
    end
    // data of commands that ended in error is never consumed here
endmodule
`default_nettype wire

// ==== test/cerr_unit_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cerr_unit_tb_top;
    logic clock = 1'b0, arstN = 1'b0, queueCreate = 1'b0, queueDelete = 1'b0;
    logic deleteIsSq = 1'b0, cmdStart = 1'b0, cmdLimitedRetry = 1'b0, mediaErr = 1'b0;
    logic readErr = 1'b0, busAbort = 1'b0, internalErr = 1'b0, execDone = 1'b0;
    logic stopOnReadErr = 1'b0, failPost = 1'b0, cplReady, cplPostFail;
    logic [3:0] queueId = 4'h0, cmdQueue = 4'h0, lag = 4'h0, cplQueue;
    logic [7:0] cmdId = 8'h00, cplCmdId, cplStatusCode;
    logic [2:0] mediaKind = 3'h0, cplStatusType;
    logic [15:0] queueAllocated;
    logic cmdBusy, dataXferEnable, recoveryAllowed, cplValid, cplRetry, fatalFlag;
    int miscompares = 0, checksDone = 0, cycles = 0;
    cerr_unit cerr_unit_i (.clock, .arst_n(arstN), .queueCreate, .queueDelete, .deleteIsSq,
        .queueId, .queueAllocated, .cmdStart, .cmdQueue, .cmdId, .cmdLimitedRetry, .cmdBusy,
        .mediaErr, .mediaKind, .readErr, .busAbort, .internalErr, .execDone, .stopOnReadErr,
        .dataXferEnable, .recoveryAllowed, .cplValid, .cplReady, .cplPostFail, .cplCmdId,
        .cplQueue, .cplStatusType, .cplStatusCode, .cplRetry,
        .controller_fatal_flag(fatalFlag));
    cerr_host_model cerr_host_model_i (.clock, .cplValid, .cplReady, .cplPostFail,
        .failPost, .lag);
    // 50 ns period
    always #25 clock = ~clock;
    // a hung wait ends the run here
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic qop(input logic cr, input logic dl, input logic sq, input logic [3:0] q);
        @(negedge clock);
        {queueCreate, queueDelete, deleteIsSq, queueId} = {cr, dl, sq, q};
        @(negedge clock);
        {queueCreate, queueDelete} = 2'b00;
    endtask
    task automatic start(input logic [3:0] q, input logic [7:0] id, input logic lr);
        @(negedge clock);
        {cmdStart, cmdQueue, cmdId, cmdLimitedRetry} = {1'b1, q, id, lr};
        @(negedge clock);
        cmdStart = 1'b0;
    endtask
    // error pulse bits: media, read, bus abort, internal, done
    task automatic ev(input logic [4:0] e, input logic [2:0] k);
        @(negedge clock);
        {mediaErr, readErr, busAbort, internalErr, execDone} = e;
        mediaKind = k;
        @(negedge clock);
        {mediaErr, readErr, busAbort, internalErr, execDone} = 5'h00;
    endtask
    task automatic cpl_check(input logic [7:0] id, input logic [2:0] st, input logic [7:0] sc,
            input logic rt);
        int n;
        for (n = 0; n < 20 && cplValid !== 1'b1; n++) @(negedge clock);
        chk("cplValid", 8'h01, {7'h0, cplValid});
        chk("cplCmdId", id, cplCmdId);
        chk("cplQueue", {4'h0, cmdQueue}, {4'h0, cplQueue});
        chk("cplStatusType", {5'h0, st}, {5'h0, cplStatusType});
        chk("cplStatusCode", sc, cplStatusCode);
        chk("cplRetry", {7'h0, rt}, {7'h0, cplRetry});
        for (n = 0; n < 20 && cplValid !== 1'b0; n++) @(negedge clock);
    endtask
    task automatic t_plain();
        start(4'h1, 8'h11, 1'b0);
        chk("cmdBusy", 8'h01, {7'h0, cmdBusy});
        chk("recoveryAllowed", 8'h01, {7'h0, recoveryAllowed});
        ev(5'h01, 3'h0);
        cpl_check(8'h11, cerr_pkg::SCT_GENERIC, cerr_pkg::SC_SUCCESS, 1'b0);
    endtask
    task automatic t_media();
        logic [7:0] codes[3] = '{cerr_pkg::SC_WRITE_FAULT, cerr_pkg::SC_UNRECOV_READ,
            cerr_pkg::SC_GUARD_ERR};
        lag = 4'h3;
        for (int k = 0; k < 3; k++) begin
            start(4'h1, 8'h20 + 8'(k), 1'b0);
            ev(5'h10, 3'(k));
            ev(5'h01, 3'h0);
            cpl_check(8'h20 + 8'(k), cerr_pkg::SCT_MEDIA, codes[k], 1'b1);
        end
        lag = 4'h0;
    endtask
    task automatic t_read();
        for (int s = 0; s < 2; s++) begin
            stopOnReadErr = 1'(s);
            start(4'h1, 8'h30, 1'b0);
            ev(5'h08, 3'h0);
            chk("dataXferEnable", 8'(1 - s), {7'h0, dataXferEnable});
            ev(5'h01, 3'h0);
            cpl_check(8'h30, cerr_pkg::SCT_MEDIA, cerr_pkg::SC_UNRECOV_READ, 1'b1);
        end
        stopOnReadErr = 1'b0;
    endtask
    task automatic t_internal();
        start(4'h1, 8'h40, 1'b1);
        chk("recoveryAllowed", 8'h00, {7'h0, recoveryAllowed});
        ev(5'h02, 3'h0);
        ev(5'h01, 3'h0);
        cpl_check(8'h40, cerr_pkg::SCT_GENERIC, cerr_pkg::SC_INTERNAL_ERR, 1'b0);
        start(4'h1, 8'h41, 1'b0);
        ev(5'h02, 3'h0);
        ev(5'h01, 3'h0);
        cpl_check(8'h41, cerr_pkg::SCT_GENERIC, cerr_pkg::SC_INTERNAL_ERR, 1'b1);
        start(4'h1, 8'h42, 1'b0);
        ev(5'h16, 3'h1);
        cpl_check(8'h42, cerr_pkg::SCT_GENERIC, cerr_pkg::SC_DATA_XFER_ERR, 1'b0);
    endtask
    task automatic t_delete();
        start(4'h2, 8'h50, 1'b0);
        qop(1'b0, 1'b1, 1'b1, 4'h2);
        cpl_check(8'h50, cerr_pkg::SCT_GENERIC, cerr_pkg::SC_ABORT_SQ_DEL, 1'b0);
        qop(1'b0, 1'b1, 1'b0, 4'h3);
        chk("queueAllocated", 8'h02, queueAllocated[7:0]);
        chk("queueAllocatedHi", 8'h00, queueAllocated[15:8]);
        start(4'h2, 8'h51, 1'b0);
        chk("cmdBusy", 8'h00, {7'h0, cmdBusy});
        // the host recreates the deleted queue and carries on with it
        qop(1'b1, 1'b0, 1'b0, 4'h2);
        start(4'h2, 8'h52, 1'b0);
        chk("cmdBusy", 8'h01, {7'h0, cmdBusy});
        ev(5'h01, 3'h0);
        cpl_check(8'h52, cerr_pkg::SCT_GENERIC, cerr_pkg::SC_SUCCESS, 1'b0);
    endtask
    task automatic t_fatal();
        failPost = 1'b1;
        for (int i = 0; i < 3; i++) begin
            start(4'h1, 8'h60, 1'b0);
            ev(5'h01, 3'h0);
            cpl_check(8'h60, cerr_pkg::SCT_GENERIC, cerr_pkg::SC_SUCCESS, 1'b0);
        end
        failPost = 1'b0;
        @(negedge clock);
        chk("fatalFlag", 8'h01, {7'h0, fatalFlag});
        start(4'h1, 8'h61, 1'b0);
        chk("cmdBusy", 8'h00, {7'h0, cmdBusy});
        repeat (20) @(negedge clock);
        chk("fatalFlag", 8'h01, {7'h0, fatalFlag});
        // software polls the flag and resets the controller
        arstN = 1'b0;
        @(negedge clock);
        arstN = 1'b1;
        chk("fatalFlag", 8'h00, {7'h0, fatalFlag});
    endtask
    initial begin
        repeat (2) @(negedge clock);
        arstN = 1'b1;
        qop(1'b1, 1'b0, 1'b0, 4'h1);
        qop(1'b1, 1'b0, 1'b0, 4'h2);
        qop(1'b1, 1'b0, 1'b0, 4'h3);
        t_plain();
        t_media();
        t_read();
        t_internal();
        t_delete();
        t_fatal();
        final_report();
    end
endmodule
`default_nettype wire
